// *** bench/tb_top.sv ***
// self-checking bench for the timer block
`timescale 1ns/1ns

module tb_top;
    logic       ref_clk   = 1'b0;
    logic       rst_b     = 1'b0;
    logic [7:0] reg_addr  = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic [1:0] ack       = 2'h0;
    logic [1:0] fire      = 2'h0;
    logic       gate      = 1'b1;
    wire  [7:0] reg_rdata;
    wire        trig;
    wire        cnt_pin;
    // tx, rx, wide pulse, second pulse, event, wide, second, first flag
    wire  [7:0] obs;
    int         errors    = 0;
    int         n_checks  = 0;
    int         cyc       = 0;
    int         a;
    int         b;
    logic [7:0] ra [6]    = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hC9};
    logic [7:0] sels [2]  = '{8'h20, 8'h10};

    always #2 ref_clk = ~ref_clk;

    tmb_timers tmb_timers_inst
    (
        .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .first_count_pin(1'b1),
        .second_count_pin(1'b1), .external_count_pin(cnt_pin),
        .trigger_pin(trig), .external_gate_pin(gate),
        .second_gate_pin(1'b1), .first_timer_vector_ack(ack[0]),
        .second_timer_vector_ack(ack[1]),
        .first_timer_overflow_flag(obs[0]),
        .second_timer_overflow_flag(obs[1]),
        .wide_timer_overflow_flag(obs[2]), .external_event_flag(obs[3]),
        .second_timer_overflow_pulse(obs[4]),
        .wide_timer_overflow_pulse(obs[5]),
        .serial_rx_clock_tick(obs[6]), .serial_tx_clock_tick(obs[7])
    );
    tmb_pin_model trig_model (.ref_clk(ref_clk), .fire(fire[0]), .pin(trig));
    tmb_pin_model cnt_model (.ref_clk(ref_clk), .fire(fire[1]), .pin(cnt_pin));

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // the run should need about a thousand cycles; this cuts a hang short
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors = errors + 1;
            finish_test();
        end
    end

    task automatic chk(input string nm, input logic [7:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] ad, d);
        @(posedge ref_clk);
        reg_addr  <= ad;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] ad, e, input string nm);
        @(posedge ref_clk);
        reg_addr <= ad;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 chk(nm, e, reg_rdata);
    endtask

    task automatic wt(input int bi, lim, input string nm);
        int k;
        k = 0;
        do
        begin
            @(posedge ref_clk);
            #1 k++;
        end
        while (obs[bi] !== 1'b1 && k < lim);
        chk(nm, 8'h01, {7'h00, obs[bi]});
    endtask

    task automatic counter_select_bit(input int n, ia, ib);
        a = 0;
        b = 0;
        repeat (n)
        begin
            @(posedge ref_clk);
            // an unknown counts as a tick so it cannot pass as zero
            #1 a += int'(obs[ia] !== 1'b0);
            b += int'(obs[ib] !== 1'b0);
        end
    endtask

    task automatic pulse_pin(input int i);
        @(posedge ref_clk);
        fire[i] <= 1'b1;
        @(posedge ref_clk);
        fire[i] <= 1'b0;
        repeat (9) @(posedge ref_clk);
    endtask

    task automatic ack_flag(input int i);
        @(posedge ref_clk);
        ack[i] <= 1'b1;
        @(posedge ref_clk);
        ack[i] <= 1'b0;
        #1 chk("flag after ack", 8'h00, {7'h00, obs[i]});
    endtask

    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge ref_clk);
        foreach (ra[i]) rd(ra[i], 8'h00, "reset value");
        wr(8'hCC, 8'h3C);
        wr(8'hCD, 8'h5A);
        repeat (20) @(posedge ref_clk);
        rd(8'hCC, 8'h3C, "stopped count low");
        rd(8'hCD, 8'h5A, "stopped count high");
        $display("test reset and hold done");
        wr(8'hCA, 8'h34);
        wr(8'hCB, 8'h12);
        wr(8'hCC, 8'hF0);
        wr(8'hCD, 8'hFF);
        wr(8'hC8, 8'h04);
        wt(2, 60, "wide flag");
        wr(8'hC8, 8'h80);
        rd(8'hCD, 8'h12, "reloaded high");
        rd(8'hC8, 8'h80, "flag kept");
        wr(8'hC8, 8'h00);
        rd(8'hC8, 8'h00, "flag cleared");
        wr(8'hCC, 8'h00);
        wr(8'hCD, 8'h00);
        wr(8'hC8, 8'h06);
        repeat (3) pulse_pin(1);
        wr(8'hC8, 8'h00);
        rd(8'hCC, 8'h03, "pin events");
        $display("test reload and counter done");
        wr(8'hC8, 8'h0C);
        pulse_pin(0);
        chk("event flag", 8'h01, {7'h00, obs[3]});
        wr(8'hC8, 8'h08);
        rd(8'hCD, 8'h12, "trigger reload");
        rd(8'hC8, 8'h08, "event cleared");
        wr(8'hC8, 8'h04);
        pulse_pin(0);
        chk("trigger ignored", 8'h00, {7'h00, obs[3]});
        wr(8'hC8, 8'h00);
        wr(8'hCB, 8'h00);
        wr(8'hCC, 8'h00);
        wr(8'hCD, 8'hAB);
        wr(8'hC8, 8'h0D);
        pulse_pin(0);
        chk("capture flag", 8'h01, {7'h00, obs[3]});
        wr(8'hC8, 8'h01);
        rd(8'hCB, 8'hAB, "captured high");
        rd(8'hCD, 8'hAB, "count kept");
        $display("test trigger done");
        wr(8'hCA, 8'hF0);
        wr(8'hCB, 8'hFF);
        foreach (sels[i])
        begin
            wr(8'hCC, 8'hF0);
            wr(8'hCD, 8'hFF);
            wr(8'hC8, sels[i] | 8'h0D);
            wt(5, 40, "wide pulse");
            counter_select_bit(160, 6, 7);
            chk("rx ticks", sels[i][5] ? 8'h0A : 8'h00, 8'(a));
            chk("tx ticks", sels[i][4] ? 8'h0A : 8'h00, 8'(b));
            chk("no baud flag", 8'h00, {7'h00, obs[2]});
            pulse_pin(0);
            chk("baud event", 8'h01, {7'h00, obs[3]});
            wr(8'hC8, sels[i]);
        end
        wr(8'hC8, 8'h00);
        $display("test baud done");
        wr(8'h89, 8'h02);
        wr(8'h8C, 8'hF0);
        wr(8'h8A, 8'hF0);
        wr(8'h88, 8'h10);
        wt(0, 300, "first flag");
        ack_flag(0);
        rd(8'h8C, 8'hF0, "reload byte kept");
        wr(8'h88, 8'h00);
        wr(8'h8D, 8'hFE);
        wr(8'h8B, 8'hFE);
        wr(8'h89, 8'h23);
        wr(8'h8C, 8'hF8);
        wr(8'h88, 8'h40);
        wt(1, 200, "second flag");
        ack_flag(1);
        wt(4, 100, "second pulse");
        wr(8'h89, 8'h33);
        repeat (2) @(posedge ref_clk);
        counter_select_bit(100, 4, 6);
        chk("held second", 8'h00, 8'(a));
        wr(8'h89, 8'h23);
        wt(4, 100, "second resumed");
        wr(8'h8A, 8'hFE);
        wr(8'h88, 8'h50);
        wt(0, 60, "split low flag");
        rd(8'h8A, 8'h00, "split low wrapped");
        @(posedge ref_clk);
        gate <= 1'b0;
        wr(8'h89, 8'h2B);
        wr(8'h8A, 8'h10);
        repeat (30) @(posedge ref_clk);
        rd(8'h8A, 8'h10, "gated low byte");
        $display("test first and second timers done");
        finish_test();
    end

endmodule // tb_top

// *** bench/tmb_pin_model.sv ***
// far-side pin model: one falling pulse per request on an idle-high pin
`timescale 1ns/1ns

module tmb_pin_model
(
    // clock
    input wire logic ref_clk,
    // request from the bench
    input wire logic fire,
    // pin toward the block
    output logic     pin
);
    logic [3:0] left = 4'h0;

    // low four cycles then high four, so pulses keep their minimum widths
    always @(posedge ref_clk)
    begin
        if (fire)
            left <= 4'h8;
        else if (left != 4'h0)
            left <= left - 4'h1;
    end

    assign pin = (left <= 4'h4);

endmodule // tmb_pin_model

// *** bench/tmb_timers_props.sv ***
// assertion checker watching the timer block ports
`timescale 1ns/1ns
`include "tmb_defs.svh"

module tmb_timers_props
(
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    // pins and acknowledges
    input wire logic       trigger_pin,
    input wire logic       first_timer_vector_ack,
    // flags, pulses and ticks
    input wire logic       first_timer_overflow_flag,
    input wire logic       wide_timer_overflow_flag,
    input wire logic       external_event_flag,
    input wire logic       second_timer_overflow_pulse,
    input wire logic       wide_timer_overflow_pulse,
    input wire logic       serial_rx_clock_tick,
    input wire logic       serial_tx_clock_tick
);
    // software-only control bits mirrored from writes: rx, tx, enable
    logic [2:0] sel_q;
    logic [3:0] age;
    logic       trig_q;
    logic       baud;
    logic       ctl_wr;

    assign baud   = sel_q[2] | sel_q[1];
    assign ctl_wr = reg_wr && reg_addr == `TMB_B_CTRL_ADDR;

    // age saturates so an old fall can never look recent
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sel_q  <= 3'h0;
            age    <= 4'hF;
            trig_q <= 1'b1;
        end
        else
        begin
            trig_q <= trigger_pin;
            if (ctl_wr)
                sel_q <= reg_wdata[5:3];
            if (trig_q && !trigger_pin)
                age <= 4'h0;
            else if (age != 4'hF)
                age <= age + 4'h1;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // the design decides on the select bits before the edge, hence $past
    AST_WTF_SET: assert property (
        wide_timer_overflow_pulse && !$past(baud)
        |-> wide_timer_overflow_flag)
        else $error("wide flag missing on overflow");
    AST_WTF_BAUD: assert property (
        $rose(wide_timer_overflow_flag) |-> !$past(baud) || $past(ctl_wr))
        else $error("wide flag set in baud use");
    AST_WTF_HOLD: assert property (
        $fell(wide_timer_overflow_flag) |-> $past(ctl_wr)
        && !$past(reg_wdata[`TMB_B_TF2]))
        else $error("wide flag cleared without software");
    AST_EXF_HOLD: assert property (
        $fell(external_event_flag) |-> $past(ctl_wr)
        && !$past(reg_wdata[`TMB_B_EXTERNAL_EVENT_FLAG]))
        else $error("event flag cleared without software");
    AST_EXF_CAUSE: assert property (
        $rose(external_event_flag) && !$past(reg_wr)
        |-> sel_q[0] && age >= 4'h1 && age <= 4'hA)
        else $error("event flag without enabled trigger fall");
    AST_TF0_CLEAR: assert property (
        $fell(first_timer_overflow_flag) |-> $past(first_timer_vector_ack)
        || ($past(reg_wr) && $past(reg_addr) == `TMB_A_CTRL_ADDR
        && !$past(reg_wdata[`TMB_A_TF0])))
        else $error("first flag cleared without cause");
    AST_RX_SRC: assert property (
        serial_rx_clock_tick |-> ($past(sel_q[2])
        ? wide_timer_overflow_pulse : second_timer_overflow_pulse))
        else $error("rx tick from wrong source");
    AST_TX_SRC: assert property (
        serial_tx_clock_tick |-> ($past(sel_q[1])
        ? wide_timer_overflow_pulse : second_timer_overflow_pulse))
        else $error("tx tick from wrong source");

    COV_WIDE: cover property (wide_timer_overflow_pulse);
    COV_EXF: cover property ($rose(external_event_flag));
    COV_TX: cover property (serial_tx_clock_tick);

endmodule // tmb_timers_props

bind tmb_timers tmb_timers_props tmb_timers_props_inst
(
    .ref_clk                     (ref_clk),
    .rst_b                       (rst_b),
    .reg_addr                    (reg_addr),
    .reg_wdata                   (reg_wdata),
    .reg_wr                      (reg_wr),
    .trigger_pin                 (trigger_pin),
    .first_timer_vector_ack      (first_timer_vector_ack),
    .first_timer_overflow_flag   (first_timer_overflow_flag),
    .wide_timer_overflow_flag    (wide_timer_overflow_flag),
    .external_event_flag         (external_event_flag),
    .second_timer_overflow_pulse (second_timer_overflow_pulse),
    .wide_timer_overflow_pulse   (wide_timer_overflow_pulse),
    .serial_rx_clock_tick        (serial_rx_clock_tick),
    .serial_tx_clock_tick        (serial_tx_clock_tick)
);

// *** core/tmb_pin_sync.sv ***
// three-stage pin synchroniser with agreement filter and falling-edge pulse
`timescale 1ns/1ns
`include "tmb_defs.svh"

module tmb_pin_sync
    import tmb_pkg::*;
(
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_b,
    // raw pins
    input  wire logic [`TMB_PINS-1:0] pin,
    // filtered level and one-cycle fall pulse
    output logic      [`TMB_PINS-1:0] level,
    output logic      [`TMB_PINS-1:0] fall
);

    tmb_sync_s st;
    tmb_sync_s next_st;
    logic [`TMB_PINS-1:0] agreed;

    // idle-high reset makes a pin held low at start give one fall pulse
    always_comb
    begin
        next_st = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        agreed = (st.s2 & st.s3) | (st.lvl & (st.s2 | st.s3));
        next_st.lvl = agreed;
        next_st.fall = st.lvl & ~agreed;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st <= '{default: '1, fall: '0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign level = st.lvl;
    assign fall  = st.fall;

endmodule // tmb_pin_sync

// *** core/tmb_timers.sv ***
// 8051-style timers: 8-bit reload and split modes plus the 16-bit timer
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`include "tmb_defs.svh"

module tmb_timers
    import tmb_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // external pins
    input  wire logic       first_count_pin,
    input  wire logic       second_count_pin,
    input  wire logic       external_count_pin,
    input  wire logic       trigger_pin,
    input  wire logic       external_gate_pin,
    input  wire logic       second_gate_pin,
    // interrupt vector acknowledges
    input  wire logic       first_timer_vector_ack,
    input  wire logic       second_timer_vector_ack,
    // interrupt flags
    output logic            first_timer_overflow_flag,
    output logic            second_timer_overflow_flag,
    output logic            wide_timer_overflow_flag,
    output logic            external_event_flag,
    // overflow pulses and serial clock ticks
    output logic            second_timer_overflow_pulse,
    output logic            wide_timer_overflow_pulse,
    output logic            serial_rx_clock_tick,
    output logic            serial_tx_clock_tick
);

    logic [1:0]           rst_sync;
    logic                 rst_q_b;
    logic [`TMB_PINS-1:0] pin_raw;
    logic [`TMB_PINS-1:0] pin_lvl;
    logic [`TMB_PINS-1:0] pin_fall;
    tmb_state_s           st;
    tmb_state_s           next_st;

    // mode decode and count events
    tmb_mode_e   mode0;
    tmb_mode_e   mode1;
    logic        mc_tick;
    logic        t0_split;
    logic        t0_ev;
    logic        t0_run;
    logic        t0_ovf;
    logic        th0_ovf;
    logic        t1_run;
    logic        t1_ovf;
    logic        baud_use;
    logic        w_run;
    logic        w_ev;
    logic        w_ovf;
    logic        trig_ev;
    logic        trig_act;
    logic        wr_hit_ctl_a;
    logic        wr_hit_ctl_w;
    logic [7:0]  rd_mux;

    // reset released through two flops
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_sync <= 2'h0;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_q_b = rst_sync[1];

    assign pin_raw = {second_gate_pin, external_gate_pin, trigger_pin,
                      external_count_pin, second_count_pin,
                      first_count_pin};

    tmb_pin_sync u_sync
    (
        .ref_clk (ref_clk),
        .rst_b   (rst_q_b),
        .pin     (pin_raw),
        .level   (pin_lvl),
        .fall    (pin_fall)
    );

    always_comb
    begin
        next_st = st;

        // machine-cycle enable from the core clock
        mc_tick = (st.mc_cnt == `TMB_MC_LAST);
        next_st.mc_cnt = mc_tick ? 4'h0 : st.mc_cnt + 4'h1;

        mode0 = tmb_mode_e'(st.mode[`TMB_M0_LSB +: 2]);
        mode1 = tmb_mode_e'(st.mode[`TMB_M1_LSB +: 2]);
        t0_split = (mode0 == TMB_MODE_SPLIT_E);

        // first timer low byte; modes 13 and 16 hold their count here
        t0_ev = st.mode[`TMB_M0_CT] ? pin_fall[`TMB_PIN_CNT0] : mc_tick;
        t0_run = st.tr0 &
                 (~st.mode[`TMB_M0_GATE] | pin_lvl[`TMB_PIN_GATE0]);
        t0_ovf = 1'b0;
        if (t0_run && t0_ev &&
            (mode0 == TMB_MODE_AUTO8_E || t0_split))
        begin
            if (st.tl0 == `TMB_BYTE_MAX)
            begin
                t0_ovf = 1'b1;
                next_st.tl0 = (mode0 == TMB_MODE_AUTO8_E) ?
                              st.th0 : `TMB_BYTE_RESET;
            end
            else
            begin
                next_st.tl0 = st.tl0 + 8'h01;
            end
        end

        // first timer high byte as a machine-cycle timer in split mode
        th0_ovf = 1'b0;
        if (t0_split && st.tr1 && mc_tick)
        begin
            th0_ovf = (st.th0 == `TMB_BYTE_MAX);
            next_st.th0 = st.th0 + 8'h01;
        end

        // second timer: only auto8 counts; split freezes like a cleared run
        // bit; while the first timer is split its run bit is borrowed, so
        // it runs whenever it is out of its own split mode
        t1_run = (mode1 != TMB_MODE_SPLIT_E) &
                 (t0_split ? 1'b1 :
                  st.tr1 & (~st.mode[`TMB_M1_GATE] |
                            pin_lvl[`TMB_PIN_GATE1]));
        t1_ovf = 1'b0;
        if (t1_run && mode1 == TMB_MODE_AUTO8_E &&
            (st.mode[`TMB_M1_CT] ? pin_fall[`TMB_PIN_CNT1] : mc_tick))
        begin
            if (st.tl1 == `TMB_BYTE_MAX)
            begin
                t1_ovf = 1'b1;
                next_st.tl1 = st.th1;
            end
            else
            begin
                next_st.tl1 = st.tl1 + 8'h01;
            end
        end

        // wide timer
        baud_use = st.wctl[`TMB_B_RCLK] | st.wctl[`TMB_B_TRANSMIT_CLOCK_SELECT];
        w_run = st.wctl[`TMB_B_TR2];
        w_ev = st.wctl[`TMB_B_COUNTER_SELECT_BIT] ?
               pin_fall[`TMB_PIN_CNTW] : 1'b1;
        w_ovf = w_run && w_ev && (st.count == `TMB_WORD_MAX);
        trig_ev = pin_fall[`TMB_PIN_TRIG] &
                  st.wctl[`TMB_B_EXTERNAL_TRIGGER_ENABLE];
        trig_act = trig_ev & ~baud_use;

        if (w_run && w_ev)
        begin
            if (w_ovf && (baud_use || !st.wctl[`TMB_B_CAPTURE_SELECT_BIT]))
            begin
                next_st.count = st.reload;
            end
            else
            begin
                next_st.count = st.count + 16'h0001;
            end
        end
        if (trig_act)
        begin
            if (st.wctl[`TMB_B_CAPTURE_SELECT_BIT])
            begin
                next_st.reload = st.count;
            end
            else
            begin
                next_st.count = st.reload;
            end
        end

        // software writes; a data write beats the same-cycle count
        wr_hit_ctl_a = reg_wr && (reg_addr == `TMB_A_CTRL_ADDR);
        wr_hit_ctl_w = reg_wr && (reg_addr == `TMB_B_CTRL_ADDR);
        if (reg_wr)
        begin
            case (reg_addr)
                `TMB_A_MODE_ADDR:  next_st.mode = reg_wdata;
                `TMB_A0_LOW_ADDR:  next_st.tl0 = reg_wdata;
                `TMB_A1_LOW_ADDR:  next_st.tl1 = reg_wdata;
                `TMB_A0_HIGH_ADDR: next_st.th0 = reg_wdata;
                `TMB_A1_HIGH_ADDR: next_st.th1 = reg_wdata;
                `TMB_B_RLD_L_ADDR: next_st.reload[7:0] = reg_wdata;
                `TMB_B_RLD_H_ADDR: next_st.reload[15:8] = reg_wdata;
                `TMB_B_CNT_L_ADDR: next_st.count[7:0] = reg_wdata;
                `TMB_B_CNT_H_ADDR: next_st.count[15:8] = reg_wdata;
                default:           next_st.mode = next_st.mode;
            endcase
        end
        if (wr_hit_ctl_a)
        begin
            next_st.tf1 = reg_wdata[`TMB_A_TF1];
            next_st.tr1 = reg_wdata[`TMB_A_TR1];
            next_st.tf0 = reg_wdata[`TMB_A_TF0];
            next_st.tr0 = reg_wdata[`TMB_A_TR0];
        end
        if (wr_hit_ctl_w)
        begin
            next_st.wctl = reg_wdata;
        end

        // vector acknowledges clear; hardware sets below win over clears
        if (first_timer_vector_ack)
        begin
            next_st.tf0 = 1'b0;
        end
        if (second_timer_vector_ack)
        begin
            next_st.tf1 = 1'b0;
        end
        if (t0_ovf)
        begin
            next_st.tf0 = 1'b1;
        end
        if (t0_split ? th0_ovf : t1_ovf)
        begin
            next_st.tf1 = 1'b1;
        end
        if (w_ovf && !baud_use)
        begin
            next_st.wctl[`TMB_B_TF2] = 1'b1;
        end
        if (trig_act || (trig_ev && baud_use))
        begin
            next_st.wctl[`TMB_B_EXTERNAL_EVENT_FLAG] = 1'b1;
        end

        // serial clock sources
        next_st.b_ovf_pulse = t1_ovf;
        next_st.w_ovf_pulse = w_ovf;
        next_st.rx_tick = st.wctl[`TMB_B_RCLK] ? w_ovf : t1_ovf;
        next_st.tx_tick = st.wctl[`TMB_B_TRANSMIT_CLOCK_SELECT] ? w_ovf : t1_ovf;

        // read data stands only in the cycle after the strobe
        case (reg_addr)
            `TMB_A_CTRL_ADDR:  rd_mux = {st.tf1, st.tr1, st.tf0, st.tr0,
                                         4'h0};
            `TMB_A_MODE_ADDR:  rd_mux = st.mode;
            `TMB_A0_LOW_ADDR:  rd_mux = st.tl0;
            `TMB_A1_LOW_ADDR:  rd_mux = st.tl1;
            `TMB_A0_HIGH_ADDR: rd_mux = st.th0;
            `TMB_A1_HIGH_ADDR: rd_mux = st.th1;
            `TMB_B_CTRL_ADDR:  rd_mux = st.wctl;
            `TMB_B_RLD_L_ADDR: rd_mux = st.reload[7:0];
            `TMB_B_RLD_H_ADDR: rd_mux = st.reload[15:8];
            `TMB_B_CNT_L_ADDR: rd_mux = st.count[7:0];
            `TMB_B_CNT_H_ADDR: rd_mux = st.count[15:8];
            default:           rd_mux = 8'h00;
        endcase
        next_st.rdata = reg_rd ? rd_mux : 8'h00;
    end

    always_ff @(posedge ref_clk or negedge rst_q_b)
    begin
        if (!rst_q_b)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign reg_rdata                   = st.rdata;
    assign first_timer_overflow_flag   = st.tf0;
    assign second_timer_overflow_flag  = st.tf1;
    assign wide_timer_overflow_flag    = st.wctl[`TMB_B_TF2];
    assign external_event_flag         = st.wctl[`TMB_B_EXTERNAL_EVENT_FLAG];
    assign second_timer_overflow_pulse = st.b_ovf_pulse;
    assign wide_timer_overflow_pulse   = st.w_ovf_pulse;
    assign serial_rx_clock_tick        = st.rx_tick;
    assign serial_tx_clock_tick        = st.tx_tick;

endmodule // tmb_timers

// *** pkg/tmb_defs.svh ***
// register addresses, field positions, reset values and counts of the timer block
`ifndef TMB_DEFS_SVH
`define TMB_DEFS_SVH

// register addresses on the special-function bus
`define TMB_A_CTRL_ADDR   8'h88
`define TMB_A_MODE_ADDR   8'h89
`define TMB_A0_LOW_ADDR   8'h8A
`define TMB_A1_LOW_ADDR   8'h8B
`define TMB_A0_HIGH_ADDR  8'h8C
`define TMB_A1_HIGH_ADDR  8'h8D
`define TMB_B_CTRL_ADDR   8'hC8
`define TMB_B_RLD_L_ADDR  8'hCA
`define TMB_B_RLD_H_ADDR  8'hCB
`define TMB_B_CNT_L_ADDR  8'hCC
`define TMB_B_CNT_H_ADDR  8'hCD

// timer_a_control fields
`define TMB_A_TF1         7
`define TMB_A_TR1         6
`define TMB_A_TF0         5
`define TMB_A_TR0         4

// timer_a_mode fields
`define TMB_M0_LSB        0
`define TMB_M0_CT         2
`define TMB_M0_GATE       3
`define TMB_M1_LSB        4
`define TMB_M1_CT         6
`define TMB_M1_GATE       7

// timer_b_control fields
`define TMB_B_TF2         7
`define TMB_B_EXTERNAL_EVENT_FLAG        6
`define TMB_B_RCLK        5
`define TMB_B_TRANSMIT_CLOCK_SELECT        4
`define TMB_B_EXTERNAL_TRIGGER_ENABLE       3
`define TMB_B_TR2         2
`define TMB_B_COUNTER_SELECT_BIT        1
`define TMB_B_CAPTURE_SELECT_BIT        0

// reset values
`define TMB_BYTE_RESET    8'h00
`define TMB_WORD_RESET    16'h0000

// modes of the first two timers
`define TMB_MODE_13       2'h0
`define TMB_MODE_16       2'h1
`define TMB_MODE_AUTO8    2'h2
`define TMB_MODE_SPLIT    2'h3

// core clocks per machine cycle, last value of the divider
`define TMB_MC_LAST       4'hB
`define TMB_BYTE_MAX      8'hFF
`define TMB_WORD_MAX      16'hFFFF

// synchronised pin slots
`define TMB_PINS          6
`define TMB_PIN_CNT0      0
`define TMB_PIN_CNT1      1
`define TMB_PIN_CNTW      2
`define TMB_PIN_TRIG      3
`define TMB_PIN_GATE0     4
`define TMB_PIN_GATE1     5

`endif

// *** pkg/tmb_pkg.sv ***
// types shared by the timer block modules
`include "tmb_defs.svh"

package tmb_pkg;

    typedef enum logic [1:0]
    {
        TMB_MODE_13_E    = `TMB_MODE_13,
        TMB_MODE_16_E    = `TMB_MODE_16,
        TMB_MODE_AUTO8_E = `TMB_MODE_AUTO8,
        TMB_MODE_SPLIT_E = `TMB_MODE_SPLIT
    } tmb_mode_e;

    typedef struct packed
    {
        logic [`TMB_PINS-1:0] s1;
        logic [`TMB_PINS-1:0] s2;
        logic [`TMB_PINS-1:0] s3;
        logic [`TMB_PINS-1:0] lvl;
        logic [`TMB_PINS-1:0] fall;
    } tmb_sync_s;

    typedef struct packed
    {
        logic [3:0]  mc_cnt;
        logic [7:0]  mode;
        logic        tf0;
        logic        tr0;
        logic        tf1;
        logic        tr1;
        logic [7:0]  tl0;
        logic [7:0]  th0;
        logic [7:0]  tl1;
        logic [7:0]  th1;
        logic [7:0]  wctl;
        logic [15:0] reload;
        logic [15:0] count;
        logic [7:0]  rdata;
        logic        b_ovf_pulse;
        logic        w_ovf_pulse;
        logic        rx_tick;
        logic        tx_tick;
    } tmb_state_s;

endpackage
